//--- core/scg_defs.svh
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// Register byte offsets on the 12-bit APB window.
`define SCG_OFF_RUN 12'h104
`define SCG_OFF_SLP 12'h114
`define SCG_OFF_DSL 12'h124
`define SCG_OFF_RCC 12'h060
`define SCG_OFF_STAT 12'h070

// Unit enable bit positions inside each gating register.
`define SCG_BIT_UART 0
`define SCG_BIT_SSI 4
`define SCG_BIT_TMR0 16
`define SCG_BIT_TMR1 17
`define SCG_BIT_CMP0 24
`define SCG_BIT_CMP1 25

// Auto clock-gate select bit inside the run clock configuration register.
`define SCG_BIT_ACG 27

// Writable bits and reset values.
`define SCG_GATE_MASK 32'h0303_0011
`define SCG_RCC_MASK 32'h0800_0000
`define SCG_GATE_RST 32'h0000_0000
`define SCG_RCC_RST 32'h0000_0000

`define SCG_NUM_UNITS 6

`endif

//--- core/scg_fault_chk.sv
`timescale 1ns/1ps

module scg_fault_chk (
	// Access from the peripheral fabric
	input wire logic i_valid,
	input wire scg_pkg::scg_unit_t i_sel,
	// Current unit enables
	input wire scg_pkg::scg_unit_t i_en,
	// Forwarded select and fault answer
	output scg_pkg::scg_unit_t o_sel,
	output logic o_fault
);
	import scg_pkg::*;

	// A gated unit never sees its select, so it cannot half-complete a transfer.
	assign o_sel = i_valid ? (i_sel & i_en) : '0;
	assign o_fault = i_valid & (|(i_sel & ~i_en));

endmodule : scg_fault_chk

//--- core/scg_gate_cell.sv
`timescale 1ns/1ps

// Latch-based clock gate: the enable only passes while the clock is low, so a
// change of enable right after a rising edge can never chop a high phase.
module scg_gate_cell (
	// Clock and enable
	input wire logic i_clk,
	input wire logic i_en,
	// Gated clock
	output logic o_gclk
);

	logic en_l;

	always_latch begin
		if (!i_clk) begin
			en_l <= i_en;
		end
	end

	assign o_gclk = i_clk & en_l;

endmodule : scg_gate_cell

//--- core/scg_pkg.sv
`include "scg_defs.svh"

package scg_pkg;

	typedef logic [31:0] scg_word_t;
	typedef logic [`SCG_NUM_UNITS-1:0] scg_unit_t;

	typedef enum logic [1:0] {
		SCG_MODE_RUN,
		SCG_MODE_SLEEP,
		SCG_MODE_DEEP
	} scg_mode_e;

	typedef struct packed {
		scg_word_t run;
		scg_word_t slp;
		scg_word_t dsl;
		scg_word_t run_clock_configuration;
		scg_word_t rdata;
		logic err;
		scg_unit_t en;
		scg_mode_e mode;
	} scg_state_s;

	// Unit order: uart, ssi, first_gp_counter_gate, second_gp_counter_gate, comparator0, comparator1.
	function automatic scg_unit_t scg_pick_units(input scg_word_t w);
		return {w[`SCG_BIT_CMP1], w[`SCG_BIT_CMP0], w[`SCG_BIT_TMR1],
			w[`SCG_BIT_TMR0], w[`SCG_BIT_SSI], w[`SCG_BIT_UART]};
	endfunction : scg_pick_units

	function automatic scg_word_t scg_apply(input scg_word_t old, input scg_word_t wdata,
		input logic [3:0] strb, input scg_word_t mask);
		scg_word_t lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return ((old & ~lanes) | (wdata & lanes)) & mask;
	endfunction : scg_apply

endpackage : scg_pkg

//--- core/scg_top.sv
`timescale 1ns/1ps
`include "scg_defs.svh"

module scg_top (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire scg_pkg::scg_word_t i_pwdata,
	input wire logic [3:0] i_pstrb,
	output scg_pkg::scg_word_t o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Power state from the core, same clock
	input wire logic i_core_sleep,
	input wire logic i_core_deep,
	// Unit clocks
	output scg_pkg::scg_unit_t o_unit_clk_en,
	output scg_pkg::scg_unit_t o_unit_clk,
	// Peripheral access check
	input wire logic i_unit_valid,
	input wire scg_pkg::scg_unit_t i_unit_sel,
	output scg_pkg::scg_unit_t o_unit_sel,
	output logic o_unit_fault
);
	import scg_pkg::*;

	localparam scg_state_s ST_RST = '{
		run: `SCG_GATE_RST,
		slp: `SCG_GATE_RST,
		dsl: `SCG_GATE_RST,
		run_clock_configuration: `SCG_RCC_RST,
		rdata: 32'h0000_0000,
		err: 1'b0,
		en: '0,
		mode: SCG_MODE_RUN
	};

	scg_state_s st_q;
	scg_state_s st_d;
	logic setup;
	logic access;
	logic wr;
	logic mapped;
	scg_word_t rd_val;
	scg_word_t stat_val;

	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable;
	assign wr = access & i_pwrite;

	assign stat_val = {22'h00_0000, st_q.mode, 2'h0, st_q.en};

	// Reserved bits never get stored, so reads of them come back as zero.
	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (i_paddr)
			`SCG_OFF_RUN: rd_val = st_q.run;
			`SCG_OFF_SLP: rd_val = st_q.slp;
			`SCG_OFF_DSL: rd_val = st_q.dsl;
			`SCG_OFF_RCC: rd_val = st_q.run_clock_configuration;
			`SCG_OFF_STAT: rd_val = stat_val;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		st_d = st_q;
		// Read data is captured in the setup phase so prdata comes from a flop.
		if (setup) begin
			st_d.rdata = i_pwrite ? 32'h0000_0000 : rd_val;
			st_d.err = ~mapped;
		end
		if (wr) begin
			unique case (i_paddr)
				`SCG_OFF_RUN: st_d.run = scg_apply(st_q.run, i_pwdata, i_pstrb, `SCG_GATE_MASK);
				`SCG_OFF_SLP: st_d.slp = scg_apply(st_q.slp, i_pwdata, i_pstrb, `SCG_GATE_MASK);
				`SCG_OFF_DSL: st_d.dsl = scg_apply(st_q.dsl, i_pwdata, i_pstrb, `SCG_GATE_MASK);
				`SCG_OFF_RCC: st_d.run_clock_configuration = scg_apply(st_q.run_clock_configuration, i_pwdata, i_pstrb, `SCG_RCC_MASK);
				default: st_d.err = st_q.err;
			endcase
		end
		// Without auto-select the run register stays in charge in every mode.
		if (!st_q.run_clock_configuration[`SCG_BIT_ACG] || !i_core_sleep) begin
			st_d.mode = SCG_MODE_RUN;
			st_d.en = scg_pick_units(st_q.run);
		end else if (i_core_deep) begin
			st_d.mode = SCG_MODE_DEEP;
			st_d.en = scg_pick_units(st_q.dsl);
		end else begin
			st_d.mode = SCG_MODE_SLEEP;
			st_d.en = scg_pick_units(st_q.slp);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_prdata = st_q.rdata;
	assign o_pready = access;
	assign o_pslverr = access & st_q.err;
	assign o_unit_clk_en = st_q.en;

	for (genvar k = 0; k < `SCG_NUM_UNITS; k++) begin : g_gate
		scg_gate_cell u_gate (
			.i_clk(i_sys_clk),
			.i_en(st_q.en[k]),
			.o_gclk(o_unit_clk[k])
		);
	end

	scg_fault_chk u_fault (
		.i_valid(i_unit_valid),
		.i_sel(i_unit_sel),
		.i_en(st_q.en),
		.o_sel(o_unit_sel),
		.o_fault(o_unit_fault)
	);

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_sys_rst);

	logic wr_slp_full;
	assign wr_slp_full = wr && (i_paddr == `SCG_OFF_SLP) && (i_pstrb == 4'hf);

	reset_clear_a: assert property (disable iff (1'b0) i_sys_rst |=>
		(st_q.slp == 32'h0000_0000) && (st_q.run == 32'h0000_0000) && (o_unit_clk_en == '0))
		else $error("gating state not cleared by reset");

	slp_write_a: assert property (wr_slp_full |=>
		st_q.slp == ($past(i_pwdata) & `SCG_GATE_MASK))
		else $error("sleep gating register did not take the write");

	rsvd_zero_a: assert property (((st_q.slp | st_q.run | st_q.dsl) & ~`SCG_GATE_MASK) == 32'h0000_0000)
		else $error("reserved gating bit is set");

	rsvd_read_a: assert property ((access && !i_pwrite && i_paddr == `SCG_OFF_SLP) |->
		(o_prdata & ~`SCG_GATE_MASK) == 32'h0000_0000 && !o_pslverr)
		else $error("reserved bits read back nonzero");

	sleep_sel_a: assert property ((i_core_sleep && !i_core_deep && st_q.run_clock_configuration[`SCG_BIT_ACG]) |=>
		o_unit_clk_en == scg_pick_units($past(st_q.slp)))
		else $error("sleep enables not taken from sleep register");

	no_acg_run_a: assert property ((!st_q.run_clock_configuration[`SCG_BIT_ACG]) |=>
		o_unit_clk_en == scg_pick_units($past(st_q.run)) && st_q.mode == SCG_MODE_RUN)
		else $error("run register not used without auto-select");

	unit_bits_a: assert property (wr_slp_full ##1 (i_core_sleep && !i_core_deep && st_q.run_clock_configuration[`SCG_BIT_ACG]) |=>
		o_unit_clk_en == {$past(i_pwdata[25], 2), $past(i_pwdata[24], 2), $past(i_pwdata[17], 2),
			$past(i_pwdata[16], 2), $past(i_pwdata[4], 2), $past(i_pwdata[0], 2)})
		else $error("unit enable bit position wrong");

	fault_gated_a: assert property ((i_unit_valid && |(i_unit_sel & ~o_unit_clk_en)) |->
		o_unit_fault && ((o_unit_sel & ~o_unit_clk_en) == '0))
		else $error("access to gated unit not faulted");

	no_fault_a: assert property ((!i_unit_valid || ((i_unit_sel & ~o_unit_clk_en) == '0)) |-> !o_unit_fault)
		else $error("fault raised for a clocked unit");

	unmapped_a: assert property ((setup && !mapped) ##1 access |-> o_pready && o_pslverr)
		else $error("unmapped address did not answer with slave error");

	sleep_gate_c: cover property (st_q.mode == SCG_MODE_SLEEP && o_unit_clk_en != '0);
	deep_gate_c: cover property (st_q.mode == SCG_MODE_DEEP);
	fault_seen_c: cover property (o_unit_fault);
	slp_write_c: cover property (wr_slp_full ##1 setup);

endmodule : scg_top

//--- test/scg_top_tb_top.sv
`timescale 1ns/1ps

module scg_top_tb_top;
	import scg_pkg::*;
	logic i_sys_clk, i_sys_rst, psel, pen, pwr, uv, sl, dp, prdy, perr, er, uf;
	logic [11:0] pa;
	logic [3:0] ps;
	scg_word_t pwd, prd, rd, slv;
	scg_unit_t cen, ck, usel, uso, expen;
	int err_total, samples_checked, i;
	int pos[6] = '{0, 4, 16, 17, 24, 25};

	scg_top DUT (
		.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(ps),
		.o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
		.i_core_sleep(sl), .i_core_deep(dp), .o_unit_clk_en(cen), .o_unit_clk(ck),
		.i_unit_valid(uv), .i_unit_sel(usel), .o_unit_sel(uso), .o_unit_fault(uf)
	);

	task check(input scg_word_t seen, input scg_word_t exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check

	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	// Request is held from setup until the edge where pready is seen high.
	task apb(input logic w, input logic [11:0] a, input scg_word_t d);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge i_sys_clk);
		pen <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			$display("unexpected at %0t: pready never came", $time);
			err_total++;
			final_report();
		end
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task rdchk(input logic [11:0] a, input scg_word_t exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask : rdchk

	// Enables are registered one edge after the register, so give them time to land.
	task settle;
		repeat (3) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
	endtask : settle

	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end

	initial begin
		{psel, pen, pwr, uv, sl, dp, er} = '0;
		pa = 12'h000;
		pwd = 32'h0000_0000;
		ps = 4'hf;
		usel = 6'h00;
		err_total = 0;
		samples_checked = 0;
		i_sys_rst = 1'b1;
		repeat (16) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		rdchk(12'h104, 32'h0000_0000);
		rdchk(12'h114, 32'h0000_0000);
		rdchk(12'h124, 32'h0000_0000);
		check(scg_word_t'(cen), 32'h0000_0000);
		$display("test reset values done");
		apb(1'b1, 12'h114, 32'hffff_ffff);
		rdchk(12'h114, 32'h0303_0011);
		// Lane 0 holds both serial enables: keep the synchronous one, drop the other.
		ps <= 4'h1;
		apb(1'b1, 12'h114, 32'h0000_0010);
		ps <= 4'hf;
		rdchk(12'h114, 32'h0303_0010);
		apb(1'b0, 12'h200, 32'h0000_0000);
		check(scg_word_t'(er), 32'h0000_0001);
		$display("test register layout done");
		slv = 32'h0303_0010;
		for (i = 0; i < 6; i++) begin
			expen[i] = slv[pos[i]];
		end
		apb(1'b1, 12'h104, 32'h0000_0000);
		apb(1'b1, 12'h124, 32'h0000_0000);
		apb(1'b1, 12'h060, 32'h0800_0000);
		sl <= 1'b1;
		settle();
		check(scg_word_t'(cen), scg_word_t'(expen));
		@(posedge i_sys_clk);
		#1;
		check(scg_word_t'(ck), scg_word_t'(expen));
		rdchk(12'h070, 32'h0000_013e);
		for (i = 0; i < 6; i++) begin
			@(posedge i_sys_clk);
			uv <= 1'b1;
			usel <= scg_unit_t'(1) << i;
			@(negedge i_sys_clk);
			check(scg_word_t'(uf), scg_word_t'(!expen[i]));
			check(scg_word_t'(uso), expen[i] ? scg_word_t'(usel) : 32'h0000_0000);
		end
		@(posedge i_sys_clk);
		uv <= 1'b0;
		// A full write while asleep exercises the bit-position assertion.
		apb(1'b1, 12'h114, 32'h0303_0010);
		settle();
		check(scg_word_t'(cen), scg_word_t'(expen));
		$display("test sleep gating done");
		apb(1'b1, 12'h060, 32'h0000_0000);
		settle();
		check(scg_word_t'(cen), 32'h0000_0000);
		apb(1'b1, 12'h060, 32'h0800_0000);
		dp <= 1'b1;
		settle();
		check(scg_word_t'(cen), 32'h0000_0000);
		$display("test mode selection done");
		final_report();
	end
endmodule : scg_top_tb_top
